// file: bcs_sequencer.sv
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.svh"
module bcs_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire bcs_pkg::bcs_sense_type senseIn,
  output bcs_pkg::bcs_drive_type driveOut,
  output logic [3:0] chargeState
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  bcs_pkg::bcs_sense_type syncA_q, sense_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      syncA_q <= '0;
      sense_q <= '0;
    end
    else
    begin
      syncA_q <= senseIn;
      sense_q <= syncA_q;
    end

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] ctrl1_q, ctrl2_q, ctrl3_q;
  logic [3:0] status_q;
  wire addrPhase = hsel && hready && htrans[1];
  wire sleepReg = sense_q.sleepState;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata <= 32'h0;
    end
    else
    begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
      if (addrPhase && !hwrite)
        case (haddr[7:0])
          `BCS_A_STATUS: hrdata <= {28'h0, status_q};
          `BCS_A_CTRL1: hrdata <= ctrl1_q;
          `BCS_A_CTRL2: hrdata <= ctrl2_q;
          `BCS_A_CTRL3: hrdata <= ctrl3_q;
          default: hrdata <= 32'h0;
        endcase
    end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire wr1 = wrPend_q && wrAddr_q == `BCS_A_CTRL1;
  wire wr2 = wrPend_q && wrAddr_q == `BCS_A_CTRL2;
  wire wr3 = wrPend_q && wrAddr_q == `BCS_A_CTRL3;

  // Sleep returns settings to defaults while charging goes on
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctrl1_q <= `BCS_C1_RST;
      ctrl2_q <= `BCS_C2_RST;
      ctrl3_q <= `BCS_C3_RST;
    end
    else if (sleepReg)
    begin
      ctrl1_q <= `BCS_C1_RST;
      ctrl2_q <= `BCS_C2_RST;
      ctrl3_q <= `BCS_C3_RST;
    end
    else
    begin
      if (wr1)
        ctrl1_q <= {23'h0, hwdata[8:0]};
      if (wr2)
        ctrl2_q <= {31'h0, hwdata[0]};
      if (wr3)
        ctrl3_q <= {27'h0, hwdata[4:0]};
    end

  wire termDis = ctrl1_q[`BCS_C1_TERMDIS];
  wire chgEn = ctrl1_q[`BCS_C1_CHGEN];
  // Timers need both the enable and live termination
  wire tmrOn = ctrl1_q[`BCS_C1_TMREN] && !termDis;
  wire reduced = sense_q.inLimitLoop || sense_q.thermLoop
    || sense_q.pathReduce;
  wire halfRate = reduced && ctrl2_q[`BCS_C2_DYN];
  wire termOk = !termDis && !sense_q.inLimitLoop
    && !sense_q.thermLoop;

  // ------------------------------------------------------------
  // Restart events
  // ------------------------------------------------------------
  logic usbP_q, acP_q, resetBit_q, chgEnP_q, rchP_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      usbP_q <= 1'b0;
      acP_q <= 1'b0;
      resetBit_q <= 1'b0;
      // Matches the enable's reset value, so reset makes no false rise
      chgEnP_q <= 1'b1;
      rchP_q <= 1'b0;
    end
    else
    begin
      usbP_q <= sense_q.usbPresent;
      acP_q <= sense_q.acPresent;
      resetBit_q <= ctrl1_q[`BCS_C1_RESET];
      chgEnP_q <= chgEn;
      rchP_q <= sense_q.batAboveRch;
    end
  wire supplyRise = (sense_q.usbPresent && !usbP_q)
    || (sense_q.acPresent && !acP_q);
  wire resetRise = ctrl1_q[`BCS_C1_RESET] && !resetBit_q;
  wire rchFall = rchP_q && !sense_q.batAboveRch;
  wire restart = supplyRise || resetRise;

  // ------------------------------------------------------------
  // Tick and timers
  // ------------------------------------------------------------
  logic [7:0] tickCnt_q;
  logic halfPh_q;
  logic [31:0] phaseTmr_q;
  logic [15:0] detTmr_q;
  bcs_pkg::bcs_state_type state_q, state_d, resume_q;
  wire tick = tickCnt_q == 8'(`BCS_TICK_CYC - 1);
  // Half rate: only every other tick counts
  wire tmrStep = tick && (!halfRate || halfPh_q)
    && !sense_q.tempFault;

  function automatic logic [31:0] tmoTicks(input logic [1:0] sel,
                                           input logic pre);
    tmoTicks = pre ? (32'(sel) + 32'h1) * 32'd1800000
                   : (32'(sel) + 32'h1) * 32'd10800000;
  endfunction : tmoTicks

  wire [31:0] preLimit = tmoTicks(ctrl3_q[`BCS_C3_PTMO], 1'b1);
  wire [31:0] fastLimit = tmoTicks(ctrl1_q[`BCS_C1_FTMO], 1'b0);
  wire inPre = state_q == bcs_pkg::BCS_PRE;
  wire inFast = state_q == bcs_pkg::BCS_FAST
    || state_q == bcs_pkg::BCS_CV;
  wire preExpire = tmrOn && inPre && phaseTmr_q >= preLimit;
  wire fastExpire = tmrOn && inFast && phaseTmr_q >= fastLimit;
  wire detDone = detTmr_q >= 16'(`BCS_DET_TICKS);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      tickCnt_q <= 8'h0;
      halfPh_q <= 1'b0;
    end
    else
    begin
      tickCnt_q <= tick ? 8'h0 : tickCnt_q + 8'h1;
      if (tick)
        halfPh_q <= !halfPh_q;
    end

  // ------------------------------------------------------------
  // Charge state machine
  // ------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bcs_pkg::BCS_OFF:
        if (chgEn && !chgEnP_q)
          state_d = bcs_pkg::BCS_SHORT;
      bcs_pkg::BCS_SHORT:
        if (sense_q.batAboveShort)
          state_d = bcs_pkg::BCS_PRE;
      bcs_pkg::BCS_PRE:
        if (preExpire)
          state_d = bcs_pkg::BCS_FAULT;
        else if (sense_q.batAboveLow)
          state_d = bcs_pkg::BCS_FAST;
      bcs_pkg::BCS_FAST:
        if (fastExpire)
          state_d = bcs_pkg::BCS_FAULT;
        else if (sense_q.batAtReg)
          state_d = bcs_pkg::BCS_CV;
      bcs_pkg::BCS_CV:
        if (fastExpire)
          state_d = bcs_pkg::BCS_FAULT;
        else if (sense_q.currAtTerm && termOk)
          state_d = bcs_pkg::BCS_DONE;
      bcs_pkg::BCS_DONE:
        if (rchFall && !termDis)
          state_d = bcs_pkg::BCS_SINK;
      bcs_pkg::BCS_SINK:
        if (!sense_q.batAboveLow)
          state_d = bcs_pkg::BCS_SRC;
        else if (detDone)
          state_d = chgEn ? bcs_pkg::BCS_PRE : bcs_pkg::BCS_OFF;
      bcs_pkg::BCS_SRC:
        if (detDone)
          state_d = sense_q.batAboveRch ? bcs_pkg::BCS_SINK2
                                        : bcs_pkg::BCS_PRE;
      bcs_pkg::BCS_SINK2:
        if (!sense_q.batAboveLow)
          state_d = bcs_pkg::BCS_SRC;
        else if (detDone)
          state_d = bcs_pkg::BCS_PRE;
      bcs_pkg::BCS_SUSP:
        if (!sense_q.tempFault)
          state_d = resume_q;
      bcs_pkg::BCS_FAULT:
        if (rchFall)
          state_d = bcs_pkg::BCS_PRE;
      default:
        state_d = bcs_pkg::BCS_OFF;
    endcase
    if (restart && state_q != bcs_pkg::BCS_OFF)
      state_d = bcs_pkg::BCS_PRE;
    if ((inPre || inFast) && sense_q.tempFault)
      state_d = bcs_pkg::BCS_SUSP;
    if (!chgEn)
      state_d = bcs_pkg::BCS_OFF;
  end

  wire phaseChange = state_d != state_q;
  wire detState = state_q == bcs_pkg::BCS_SINK
    || state_q == bcs_pkg::BCS_SRC || state_q == bcs_pkg::BCS_SINK2;
  wire suspending = state_d == bcs_pkg::BCS_SUSP;
  wire resuming = state_q == bcs_pkg::BCS_SUSP;
  // Fast timer runs from fast start across CV; frozen while suspended
  wire keepTmr = suspending || resuming
    || (state_q == bcs_pkg::BCS_FAST && state_d == bcs_pkg::BCS_CV);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_q <= bcs_pkg::BCS_OFF;
      resume_q <= bcs_pkg::BCS_PRE;
      phaseTmr_q <= 32'h0;
      detTmr_q <= 16'h0;
    end
    else
    begin
      state_q <= state_d;
      if (suspending && !resuming)
        resume_q <= state_q;
      if (phaseChange && !keepTmr)
        phaseTmr_q <= 32'h0;
      else if (tmrStep && (inPre || inFast))
        phaseTmr_q <= phaseTmr_q + 32'h1;
      if (phaseChange || !detState)
        detTmr_q <= 16'h0;
      else if (tick)
        detTmr_q <= detTmr_q + 16'h1;
    end

  // ------------------------------------------------------------
  // Status flags, set wins over clear
  // ------------------------------------------------------------
  wire doneSet = state_d == bcs_pkg::BCS_DONE
    && state_q == bcs_pkg::BCS_CV;
  wire removal = state_q == bcs_pkg::BCS_SINK
    && !sense_q.batAboveLow;
  wire clrTo = restart || rchFall;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      status_q <= 4'h0;
    else
    begin
      if (doneSet)
        status_q[`BCS_S_DONE] <= 1'b1;
      else if (state_d == bcs_pkg::BCS_PRE)
        status_q[`BCS_S_DONE] <= 1'b0;
      if (fastExpire)
        status_q[`BCS_S_FTO] <= 1'b1;
      else if (clrTo)
        status_q[`BCS_S_FTO] <= 1'b0;
      if (preExpire)
        status_q[`BCS_S_PTO] <= 1'b1;
      else if (clrTo)
        status_q[`BCS_S_PTO] <= 1'b0;
      if (removal)
        status_q[`BCS_S_PTE] <= 1'b1;
      else if (state_d == bcs_pkg::BCS_PRE)
        status_q[`BCS_S_PTE] <= 1'b0;
    end

  // ------------------------------------------------------------
  // Drive outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
    if (rst)
      driveOut <= '0;
    else
    begin
      driveOut.chargeOn <= inPre || inFast
        || state_q == bcs_pkg::BCS_SRC;
      // Fixed ratio, no register reaches it
      driveOut.preCurrent <= inPre
        || state_q == bcs_pkg::BCS_SRC;
      driveOut.cvMode <= state_q == bcs_pkg::BCS_CV;
      driveOut.detSink <= state_q == bcs_pkg::BCS_SINK
        || state_q == bcs_pkg::BCS_SINK2;
      driveOut.detSource <= state_q == bcs_pkg::BCS_SRC;
      driveOut.shortTest <= state_q == bcs_pkg::BCS_SHORT;
      driveOut.fastCurrent <= ctrl1_q[`BCS_C1_ICHG];
      driveOut.termLevel <= ctrl3_q[`BCS_C3_TERMF];
      driveOut.tempWindow <= ctrl3_q[`BCS_C3_TEMP_WINDOW_SELECT];
      driveOut.thermKind <= ctrl1_q[`BCS_C1_NTC];
    end
  assign chargeState = state_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_done_sets;
    @(posedge clk) disable iff (rst)
    doneSet |=> status_q[`BCS_S_DONE] && state_q == bcs_pkg::BCS_DONE;
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("done flag not set");
  property p_no_term_loop;
    @(posedge clk) disable iff (rst)
    state_q == bcs_pkg::BCS_CV && (sense_q.thermLoop
      || sense_q.inLimitLoop || termDis) |=> state_q != bcs_pkg::BCS_DONE;
  endproperty
  a_no_term_loop: assert property (p_no_term_loop)
    else $error("termination while loop active");
  property p_timers_off;
    @(posedge clk) disable iff (rst)
    termDis |-> !preExpire && !fastExpire;
  endproperty
  a_timers_off: assert property (p_timers_off)
    else $error("timer active with termination off");
  property p_freeze;
    @(posedge clk) disable iff (rst)
    state_q == bcs_pkg::BCS_SUSP && state_d == bcs_pkg::BCS_SUSP
      |=> $stable(phaseTmr_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("timer moved in suspend");
  property p_pre_to_fast;
    @(posedge clk) disable iff (rst)
    inPre && sense_q.batAboveLow && chgEn && !preExpire && !restart
      && !sense_q.tempFault |=> state_q == bcs_pkg::BCS_FAST;
  endproperty
  a_pre_to_fast: assert property (p_pre_to_fast)
    else $error("no fast charge");
  property p_fto;
    @(posedge clk) disable iff (rst)
    fastExpire |=> status_q[`BCS_S_FTO] && !status_q[`BCS_S_DONE] ##0
      !$rose(status_q[`BCS_S_PTO]);
  endproperty
  a_fto: assert property (p_fto)
    else $error("fast timeout flag wrong");
  property p_restart;
    @(posedge clk) disable iff (rst)
    restart && chgEn && state_q != bcs_pkg::BCS_OFF && !preExpire
      && !fastExpire |=> !status_q[`BCS_S_FTO] && !status_q[`BCS_S_PTO];
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear faults");
  property p_removal;
    @(posedge clk) disable iff (rst)
    removal |=> status_q[`BCS_S_PTE] ##1 driveOut.detSource;
  endproperty
  a_removal: assert property (p_removal)
    else $error("removal not flagged");
  property p_sleep;
    @(posedge clk) disable iff (rst)
    sleepReg |=> ctrl2_q == `BCS_C2_RST && ctrl1_q == `BCS_C1_RST;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not restore defaults");
endmodule : bcs_sequencer
`default_nettype wire

// file: bcs_defs.svh
// Summary of operation
// - Precharge current is always one tenth of fast-charge current, not adjustable.
// - Leave precharge for fast charge once battery passes the low threshold.
// - At regulation voltage enter constant-voltage phase and hold it.
// - At termination current set the charge-done flag and turn charger off.
// - Suppress termination while input-limit or thermal loop is active.
// - Safety timer runs at half rate while charge current is reduced.
// - Two-bit termination threshold field, default 7.5 percent; avoid 2.5 percent.
// - Termination enabled at reset; disable bit keeps charger in CV, no detection.
// - Both safety timers are off while termination is disabled.
// - Below recharge threshold run sink test; still present and enabled restarts charge.
// - After removal, alternate source and sink tests until battery found or disabled.
// - Battery removal also raises the pack thermal error flag.
// - Separate fast and precharge timeouts; timer-enable cleared disables safety timers.
// - Half-rate timing enabled at reset; clearing its bit forces full rate.
// - Full rate and termination return only once both reduction loops are inactive.
// - Timer fault when precharge or fast-charge phase outlasts its timeout.
// - Fast and precharge timeout faults sit in separate status bits.
// - Supply rise, reset-bit rise or recharge drop clear faults and restart charge.
// - Temperature fault suspends charging and freezes timer; resume without reset.
// - Range-select bit picks a 0-45 or 0-60 degree charging window.
// - Thermistor-type bit switches thresholds from 10k to 100k thermistor.
// - Sleep state keeps charging but returns all registers to defaults; the code restores only the three control registers, and status keeps its flags.
// - On charger enable first check the battery terminal for a short.
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH
`define BCS_A_STATUS 8'h00
`define BCS_A_CTRL1 8'h04
`define BCS_A_CTRL2 8'h08
`define BCS_A_CTRL3 8'h0C
// Control one fields
`define BCS_C1_TERMDIS 0
`define BCS_C1_TMREN 1
`define BCS_C1_CHGEN 2
`define BCS_C1_RESET 3
`define BCS_C1_NTC 4
`define BCS_C1_FTMO 6:5
`define BCS_C1_ICHG 8:7
`define BCS_C1_RST 32'h0000_0006
// Control two
`define BCS_C2_DYN 0
`define BCS_C2_RST 32'h0000_0001
// Control three
`define BCS_C3_TERMF 1:0
`define BCS_C3_TEMP_WINDOW_SELECT 2
`define BCS_C3_PTMO 4:3
`define BCS_C3_RST 32'h0000_0002
// Status bits
`define BCS_S_DONE 0
`define BCS_S_FTO 1
`define BCS_S_PTO 2
`define BCS_S_PTE 3
// Timing: tick period and detection interval
`define BCS_TICK_NS 1000
`define BCS_CLK_NS 4
`define BCS_TICK_CYC (`BCS_TICK_NS / `BCS_CLK_NS)
`define BCS_DET_US 250
`define BCS_DET_TICKS `BCS_DET_US
`define BCS_DEB_CYC 16
`endif

// file: bcs_pkg.sv
package bcs_pkg;
  typedef enum logic [3:0] {
    BCS_OFF, BCS_SHORT, BCS_PRE, BCS_FAST, BCS_CV, BCS_DONE,
    BCS_SINK, BCS_SRC, BCS_SINK2, BCS_SUSP, BCS_FAULT
  } bcs_state_type;
  typedef struct packed {
    logic batAboveLow;
    logic batAboveRch;
    logic batAtReg;
    logic batAboveShort;
    logic currAtTerm;
    logic inLimitLoop;
    logic thermLoop;
    logic pathReduce;
    logic tempFault;
    logic usbPresent;
    logic acPresent;
    logic sleepState;
  } bcs_sense_type;
  typedef struct packed {
    logic chargeOn;
    logic preCurrent;
    logic cvMode;
    logic detSink;
    logic detSource;
    logic shortTest;
    logic [1:0] fastCurrent;
    logic [1:0] termLevel;
    logic tempWindow;
    logic thermKind;
  } bcs_drive_type;
endpackage : bcs_pkg

// file: bcs_battery_pack.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Single-cell pack with thermistor, seen through the sense levels
// ----------------------------------------------------------------
module bcs_battery_pack (
  input wire logic present,
  input wire logic [2:0] level,
  input wire logic taper,
  input wire bcs_pkg::bcs_sense_type sysIn,
  input wire bcs_pkg::bcs_drive_type driveIn,
  output bcs_pkg::bcs_sense_type senseOut
);
  logic floatUp;
  // Empty socket: a sourced current floats the pin up, a sink pulls it down
  assign floatUp = driveIn.detSource && !driveIn.detSink;
  always_comb
  begin
    senseOut = sysIn;
    senseOut.batAboveShort = present ? (level >= 3'h1) : floatUp;
    senseOut.batAboveLow = present ? (level >= 3'h2) : floatUp;
    senseOut.batAboveRch = present ? (level >= 3'h3) : floatUp;
    senseOut.batAtReg = present ? (level >= 3'h4) : floatUp;
    // Current only tapers while the charger holds the voltage
    senseOut.currAtTerm = present && taper && driveIn.cvMode;
  end
endmodule : bcs_battery_pack
`default_nettype wire

// file: test_battery_charge_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defs.svh"
module test_battery_charge_sequencer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] chargeState;
  logic present = 1'b1;
  logic [2:0] level = 3'h0;
  logic taper = 1'b0;
  bcs_pkg::bcs_sense_type sysIn = '0;
  bcs_pkg::bcs_sense_type senseIn;
  bcs_pkg::bcs_drive_type driveOut;
  logic [31:0] rdData;
  int miscompares = 0;
  int samplesChecked = 0;

  always #2 clk = ~clk;

  bcs_sequencer u_dut (.clk(clk), .rst(rst), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .senseIn(senseIn),
    .driveOut(driveOut), .chargeState(chargeState));

  bcs_battery_pack u_pack (.present(present), .level(level),
    .taper(taper), .sysIn(sysIn), .driveIn(driveOut),
    .senseOut(senseIn));

  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic busCycle(input logic [7:0] addr, input logic wr,
                          input logic [31:0] wd);
    @(posedge clk);
    haddr <= {24'h0, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdData = hrdata;
  endtask : busCycle

  task automatic regCheck(input string what, input logic [7:0] addr,
                          input logic [31:0] exp);
    busCycle(addr, 1'b0, 32'h0);
    check(what, exp, rdData);
  endtask : regCheck

  // Sampled on the falling edge so the launching edge has settled
  task automatic waitState(input logic [3:0] st, input int lim);
    int n;
    for (n = 0; n < lim && chargeState !== st; n++) @(negedge clk);
    check("chargeState", {28'h0, st}, {28'h0, chargeState});
    @(negedge clk);
  endtask : waitState

  task automatic completeRun;
    if (miscompares == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : completeRun

  // ----------------------------------------------------------------
  // Watchdog: the detection interval dominates, about 63k cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    completeRun();
  end

  // ----------------------------------------------------------------
  // Main sequence; safety timeouts run seconds and are left out
  // ----------------------------------------------------------------
  initial
  begin
    int i;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    regCheck("status", `BCS_A_STATUS, 32'h0);
    regCheck("ctrl one", `BCS_A_CTRL1, `BCS_C1_RST);
    regCheck("ctrl two", `BCS_A_CTRL2, `BCS_C2_RST);
    regCheck("ctrl three", `BCS_A_CTRL3, `BCS_C3_RST);
    regCheck("unmapped", 8'h10, 32'h0);
    waitState(bcs_pkg::BCS_OFF, 0);
    for (i = 0; i < 4; i++)
    begin
      busCycle(`BCS_A_CTRL3, 1'b1, 32'(i) | (32'(i & 1) << 2));
      repeat (4) @(negedge clk);
      check("termLevel", 32'(i), {30'h0, driveOut.termLevel});
      check("tempWindow", 32'(i & 1), {31'h0, driveOut.tempWindow});
    end
    busCycle(`BCS_A_CTRL3, 1'b1, `BCS_C3_RST);
    busCycle(`BCS_A_CTRL1, 1'b1, 32'h12);
    repeat (4) @(negedge clk);
    check("thermKind", 32'h1, {31'h0, driveOut.thermKind});
    // Charging only starts on a rising enable
    @(posedge clk);
    level <= 3'h1;
    busCycle(`BCS_A_CTRL1, 1'b1, 32'h182);
    busCycle(`BCS_A_CTRL1, 1'b1, 32'h186);
    waitState(bcs_pkg::BCS_SHORT, 50);
    check("shortTest", 32'h1, {31'h0, driveOut.shortTest});
    waitState(bcs_pkg::BCS_PRE, 50);
    check("preCurrent", 32'h1, {31'h0, driveOut.preCurrent});
    check("fastCurrent", 32'h3, {30'h0, driveOut.fastCurrent});
    @(posedge clk);
    level <= 3'h2;
    waitState(bcs_pkg::BCS_FAST, 50);
    check("preCurrent", 32'h0, {31'h0, driveOut.preCurrent});
    @(posedge clk);
    sysIn.tempFault <= 1'b1;
    waitState(bcs_pkg::BCS_SUSP, 50);
    check("chargeOn", 32'h0, {31'h0, driveOut.chargeOn});
    @(posedge clk);
    sysIn.tempFault <= 1'b0;
    waitState(bcs_pkg::BCS_FAST, 50);
    @(posedge clk);
    level <= 3'h4;
    waitState(bcs_pkg::BCS_CV, 50);
    check("cvMode", 32'h1, {31'h0, driveOut.cvMode});
    @(posedge clk);
    sysIn.inLimitLoop <= 1'b1;
    taper <= 1'b1;
    repeat (30) @(negedge clk);
    waitState(bcs_pkg::BCS_CV, 0);
    @(posedge clk);
    sysIn.inLimitLoop <= 1'b0;
    waitState(bcs_pkg::BCS_DONE, 50);
    check("chargeOn", 32'h0, {31'h0, driveOut.chargeOn});
    regCheck("status", `BCS_A_STATUS, 32'h1);
    regCheck("unmapped", 8'h10, 32'h0);
    busCycle(8'h14, 1'b1, 32'h0);
    regCheck("ctrl one", `BCS_A_CTRL1, 32'h186);
    // Pack pulled out while idle after termination
    @(posedge clk);
    present <= 1'b0;
    taper <= 1'b0;
    waitState(bcs_pkg::BCS_SINK, 50);
    check("detSink", 32'h1, {31'h0, driveOut.detSink});
    waitState(bcs_pkg::BCS_SRC, 50);
    check("detSource", 32'h1, {31'h0, driveOut.detSource});
    busCycle(`BCS_A_STATUS, 1'b0, 32'h0);
    check("pack thermal error", 32'h1, {31'h0, rdData[3]});
    // No pack: the sourced current floats the pin above recharge level
    waitState(bcs_pkg::BCS_SINK2, 64000);
    waitState(bcs_pkg::BCS_SRC, 50);
    @(posedge clk);
    present <= 1'b1;
    level <= 3'h2;
    busCycle(`BCS_A_CTRL1, 1'b1, 32'h18E);
    waitState(bcs_pkg::BCS_FAST, 50);
    busCycle(`BCS_A_CTRL1, 1'b1, 32'h187);
    level <= 3'h4;
    taper <= 1'b1;
    waitState(bcs_pkg::BCS_CV, 50);
    repeat (40) @(negedge clk);
    waitState(bcs_pkg::BCS_CV, 0);
    @(posedge clk);
    sysIn.sleepState <= 1'b1;
    repeat (6) @(negedge clk);
    regCheck("ctrl one", `BCS_A_CTRL1, `BCS_C1_RST);
    busCycle(`BCS_A_CTRL2, 1'b1, 32'h0);
    regCheck("ctrl two", `BCS_A_CTRL2, `BCS_C2_RST);
    completeRun();
  end
endmodule : test_battery_charge_sequencer
`default_nettype wire
